// ---- rtl/isr_defs.vh ----
`ifndef ISR_DEFS_VH
`define ISR_DEFS_VH
`define ISR_IDX_PIXELS 4'h0
`define ISR_IDX_LINES 4'h1
`define ISR_IDX_DELAY 4'h2
`define ISR_IDX_BLANK 4'h3
`define ISR_IDX_MODE 4'h4
`define ISR_IDX_STATUS 4'h8
`define ISR_RST_PIXELS 12'h010
`define ISR_RST_LINES 12'h008
`define ISR_RST_DELAY 12'h000
`define ISR_RST_BLANK 12'h004
`define ISR_RST_MODE 12'h000
`define ISR_MODE_ONE_OUT 0
`define ISR_DLY_PV_LSB 0
`define ISR_DLY_END_LSB 4
`define ISR_DLY_CODE_OFS 4'h2
`define ISR_SR_LEN 13
`define ISR_TAP_AOUT_TWO 3
`define ISR_TAP_AOUT_ONE 4
`define ISR_TAP_ADC_TWO 7
`define ISR_TAP_ADC_ONE 8
`define ISR_UPLOAD_BITS 16
`endif

// ---- rtl/isr_top.v ----
// The register addresses and the APB register port were chosen for this implementation.
`include "isr_defs.vh"

module isr_top
(
  input wire i_clk,
  input wire i_reset,
  input wire i_line_adv,
  input wire i_frame_start,
  input wire i_par_sclk,
  input wire i_par_sdata,
  input wire i_par_load,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  output reg o_pix_valid,
  output reg o_eol,
  output reg o_eof,
  output reg o_sample_signal,
  output reg o_sample_reset,
  output reg o_analog_output_a_valid,
  output reg o_analog_output_b_valid,
  output reg o_adc_clk,
  output reg o_adc_valid
);

  // ****************************************
  // states and helpers
  // ****************************************
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_HOLD = 2'b01;
  localparam [1:0] ST_BLANK = 2'b10;
  localparam [1:0] ST_READ = 2'b11;

  // delay setting to added clocks
  function [3:0] dly_amt;
    input [3:0] code;
    begin
      if (code > `ISR_DLY_CODE_OFS)
        dly_amt = code - `ISR_DLY_CODE_OFS;
      else
        dly_amt = 4'h0;
    end
  endfunction

  // pick a delayed copy of a raw marker
  function tap_sel;
    input raw;
    input [`ISR_SR_LEN-1:0] sr;
    input [3:0] amt;
    begin
      if (amt == 4'h0)
        tap_sel = raw;
      else
        tap_sel = sr[amt-4'h1];
    end
  endfunction

  // ****************************************
  // parameter registers
  // ****************************************
  reg [11:0] pixels_reg;
  reg [11:0] lines_reg;
  reg [11:0] delay_reg;
  reg [11:0] blank_reg;
  reg [11:0] mode_reg;
  reg [15:0] shift_reg;
  reg sclk_d_reg;
  reg load_d_reg;
  wire sclk_rise;
  wire load_rise;
  wire apb_wr;
  wire apb_rd;
  wire addr_ok;
  wire [3:0] apb_idx;
  reg [3:0] wr_idx;
  reg [11:0] wr_data;
  reg wr_en;

  assign sclk_rise = i_par_sclk & ~sclk_d_reg;
  assign load_rise = i_par_load & ~load_d_reg;
  assign apb_idx = i_paddr[5:2];
  assign addr_ok = (i_paddr[11:6] == 6'h00) && (i_paddr[1:0] == 2'b00);
  assign apb_wr = i_psel & i_penable & i_pwrite & ~o_pready;
  assign apb_rd = i_psel & i_penable & ~i_pwrite & ~o_pready;

  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      sclk_d_reg <= 1'b0;
      load_d_reg <= 1'b0;
      shift_reg <= 16'h0000;
    end
    else
    begin
      sclk_d_reg <= i_par_sclk;
      load_d_reg <= i_par_load;
      if (sclk_rise)
        shift_reg <= {shift_reg[14:0], i_par_sdata};
    end
  end

  // serial load wins over a bus write in the same cycle
  always @*
  begin
    wr_en = 1'b0;
    wr_idx = apb_idx;
    wr_data = i_pwdata[11:0];
    if (load_rise)
    begin
      wr_en = 1'b1;
      wr_idx = shift_reg[15:12];
      wr_data = shift_reg[11:0];
    end
    else if (apb_wr && addr_ok)
      wr_en = 1'b1;
  end

  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      pixels_reg <= `ISR_RST_PIXELS;
      lines_reg <= `ISR_RST_LINES;
      delay_reg <= `ISR_RST_DELAY;
      blank_reg <= `ISR_RST_BLANK;
      mode_reg <= `ISR_RST_MODE;
    end
    else if (wr_en)
    begin
      case (wr_idx)
        `ISR_IDX_PIXELS: pixels_reg <= wr_data;
        `ISR_IDX_LINES: lines_reg <= wr_data;
        `ISR_IDX_DELAY: delay_reg <= wr_data;
        `ISR_IDX_BLANK: blank_reg <= wr_data;
        `ISR_IDX_MODE: mode_reg <= wr_data;
        default: ;
      endcase
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  reg [1:0] state_reg;
  reg [11:0] cnt_reg;
  reg [11:0] line_cnt_reg;
  reg pv_raw_reg;
  reg pv_d_reg;
  reg eol_raw_reg;
  reg eof_raw_reg;
  reg last_line_reg;
  wire pv_fall;
  wire [11:0] half_blank;

  assign pv_fall = pv_d_reg & ~pv_raw_reg;
  assign half_blank = {1'b0, blank_reg[11:1]};

  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 12'h000;
      line_cnt_reg <= 12'h000;
      pv_raw_reg <= 1'b0;
      last_line_reg <= 1'b0;
      o_sample_signal <= 1'b0;
      o_sample_reset <= 1'b0;
    end
    else if (i_frame_start)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 12'h000;
      line_cnt_reg <= 12'h000;
      pv_raw_reg <= 1'b0;
      o_sample_signal <= 1'b0;
      o_sample_reset <= 1'b0;
    end
    else if (i_line_adv)
    begin
      state_reg <= ST_HOLD;
      cnt_reg <= 12'h000;
      pv_raw_reg <= 1'b0;
      o_sample_signal <= 1'b0;
      o_sample_reset <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE: ;
        ST_HOLD:
        begin
          state_reg <= ST_BLANK;
          cnt_reg <= 12'h000;
          o_sample_signal <= 1'b1;
        end
        ST_BLANK:
        begin
          cnt_reg <= cnt_reg + 12'h001;
          o_sample_signal <= (cnt_reg + 12'h001) < half_blank;
          o_sample_reset <= (cnt_reg + 12'h001) >= half_blank;
          if (cnt_reg + 12'h001 >= blank_reg)
          begin
            state_reg <= ST_READ;
            cnt_reg <= 12'h000;
            o_sample_signal <= 1'b0;
            o_sample_reset <= 1'b0;
            pv_raw_reg <= 1'b1;
            line_cnt_reg <= line_cnt_reg + 12'h001;
            last_line_reg <= (line_cnt_reg + 12'h001) == lines_reg;
          end
        end
        ST_READ:
        begin
          cnt_reg <= cnt_reg + 12'h001;
          if (cnt_reg + 12'h001 >= pixels_reg)
          begin
            state_reg <= ST_IDLE;
            pv_raw_reg <= 1'b0;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      pv_d_reg <= 1'b0;
      eol_raw_reg <= 1'b0;
      eof_raw_reg <= 1'b0;
    end
    else
    begin
      pv_d_reg <= pv_raw_reg;
      eol_raw_reg <= pv_fall;
      eof_raw_reg <= pv_fall & last_line_reg;
    end
  end

  // ****************************************
  // marker delay and output timing
  // ****************************************
  reg [`ISR_SR_LEN-1:0] pv_sr_reg;
  reg [`ISR_SR_LEN-1:0] eol_sr_reg;
  reg [`ISR_SR_LEN-1:0] eof_sr_reg;
  wire [3:0] pv_amt;
  wire [3:0] end_amt;
  wire one_out;

  assign pv_amt = dly_amt(delay_reg[`ISR_DLY_PV_LSB+3:`ISR_DLY_PV_LSB]);
  assign end_amt = dly_amt(delay_reg[`ISR_DLY_END_LSB+3:`ISR_DLY_END_LSB]);
  assign one_out = mode_reg[`ISR_MODE_ONE_OUT];

  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      pv_sr_reg <= {`ISR_SR_LEN{1'b0}};
      eol_sr_reg <= {`ISR_SR_LEN{1'b0}};
      eof_sr_reg <= {`ISR_SR_LEN{1'b0}};
      o_pix_valid <= 1'b0;
      o_eol <= 1'b0;
      o_eof <= 1'b0;
      o_analog_output_a_valid <= 1'b0;
      o_analog_output_b_valid <= 1'b0;
      o_adc_clk <= 1'b0;
      o_adc_valid <= 1'b0;
    end
    else
    begin
      pv_sr_reg <= {pv_sr_reg[`ISR_SR_LEN-2:0], pv_raw_reg};
      eol_sr_reg <= {eol_sr_reg[`ISR_SR_LEN-2:0], eol_raw_reg};
      eof_sr_reg <= {eof_sr_reg[`ISR_SR_LEN-2:0], eof_raw_reg};
      o_pix_valid <= tap_sel(pv_raw_reg, pv_sr_reg, pv_amt);
      o_eol <= tap_sel(eol_raw_reg, eol_sr_reg, end_amt);
      o_eof <= tap_sel(eof_raw_reg, eof_sr_reg, end_amt);
      if (one_out)
      begin
        o_analog_output_a_valid <= pv_sr_reg[`ISR_TAP_AOUT_ONE];
        o_analog_output_b_valid <= 1'b0;
        o_adc_valid <= pv_sr_reg[`ISR_TAP_ADC_ONE];
      end
      else
      begin
        o_analog_output_a_valid <= pv_sr_reg[`ISR_TAP_AOUT_TWO];
        o_analog_output_b_valid <= pv_sr_reg[`ISR_TAP_AOUT_TWO];
        o_adc_valid <= pv_sr_reg[`ISR_TAP_ADC_TWO];
      end
      o_adc_clk <= ~o_adc_clk;
    end
  end

  // ****************************************
  // bus slave
  // ****************************************
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end
    else
    begin
      o_pready <= i_psel & i_penable & ~o_pready;
      o_pslverr <= (apb_wr | apb_rd) & ~addr_ok;
      o_prdata <= 32'h0000_0000;
      if (apb_rd && addr_ok)
      begin
        case (apb_idx)
          `ISR_IDX_PIXELS: o_prdata <= {20'h0_0000, pixels_reg};
          `ISR_IDX_LINES: o_prdata <= {20'h0_0000, lines_reg};
          `ISR_IDX_DELAY: o_prdata <= {20'h0_0000, delay_reg};
          `ISR_IDX_BLANK: o_prdata <= {20'h0_0000, blank_reg};
          `ISR_IDX_MODE: o_prdata <= {20'h0_0000, mode_reg};
          `ISR_IDX_STATUS: o_prdata <= {16'h0000, 2'b00, state_reg, line_cnt_reg};
          default: o_prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// ---- sim/isr_ctrl_model.sv ----
// ****
// camera controller model
// ****
module isr_ctrl_model (
  input wire logic i_clk,
  output logic o_line_adv,
  output logic o_frame_start,
  output logic o_sclk,
  output logic o_sdata,
  output logic o_load
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {o_line_adv, o_frame_start, o_sclk, o_sdata, o_load} = '0;
  task line(input int h);
    @(posedge i_clk) o_line_adv <= 1;
    repeat (h) @(posedge i_clk);
    o_line_adv <= 0;
  endtask
  task frame;
    @(posedge i_clk) o_frame_start <= 1;
    repeat (3) @(posedge i_clk);
    o_frame_start <= 0;
  endtask
  task upload(input logic [15:0] w);
    for (int i = 15; i >= 0; i--)
    begin
      @(posedge i_clk);
      o_sclk <= 0;
      o_sdata <= w[i];
      @(posedge i_clk) o_sclk <= 1;
    end
    @(posedge i_clk);
    o_sclk <= 0;
    o_sdata <= ~w[0];
    o_load <= 1;
    @(posedge i_clk) o_load <= 0;
  endtask
endmodule

// ---- sim/isr_top_sva.sv ----
// ****
// checker
// ****
module isr_top_sva (
  input wire i_clk,
  input wire i_reset,
  input wire i_line_adv,
  input wire o_pix_valid,
  input wire o_eol,
  input wire o_eof,
  input wire o_sample_signal,
  input wire o_sample_reset,
  input wire o_analog_output_a_valid,
  input wire o_analog_output_b_valid,
  input wire o_adc_clk,
  input wire o_adc_valid
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  chk_eol_after_pv: assert property ($fell(o_pix_valid) |=> o_eol)
    else $error("eol not one cycle after pixel valid");
  chk_eof_with_eol: assert property (o_eof |-> o_eol)
    else $error("eof without eol");
  chk_hold_suspends: assert property (i_line_adv [*2] |=> !o_sample_signal && !o_sample_reset)
    else $error("sequencer runs while line strobe high");
  chk_blank_order: assert property ($rose(o_sample_reset) |-> $past(o_sample_signal))
    else $error("reset sample not after signal sample");
  chk_b_needs_a: assert property (o_analog_output_b_valid |-> o_analog_output_a_valid)
    else $error("output b valid alone");
  chk_adc_lag: assert property ($rose(o_analog_output_a_valid) |-> ##4 $rose(o_adc_valid))
    else $error("converter latency wrong");
  chk_adc_clk_half: assert property (!$past(i_reset) |-> o_adc_clk != $past(o_adc_clk))
    else $error("converter clock not half rate");
  chk_reset_quiet: assert property (disable iff (1'b0) i_reset |=> !o_pix_valid && !o_eol && !o_eof)
    else $error("markers active after reset");
  cover property (o_eof);
  cover property (o_analog_output_b_valid);
  cover property ($rose(o_adc_valid));
endmodule
bind isr_top isr_top_sva isr_top_sva_inst (.i_clk, .i_reset, .i_line_adv, .o_pix_valid, .o_eol, .o_eof,
  .o_sample_signal, .o_sample_reset, .o_analog_output_a_valid, .o_analog_output_b_valid, .o_adc_clk, .o_adc_valid);

// ---- sim/isr_top_tb.sv ----
// ****
// testbench
// ****
module isr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0, i_reset = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, err;
  logic [11:0] i_paddr = '0;
  logic [31:0] i_pwdata = '0, rdv;
  wire [31:0] o_prdata;
  wire o_pready, o_pslverr, o_pix_valid, o_eol, o_eof, o_sample_signal, o_sample_reset, a_v, b_v, adc_v;
  wire line_adv, frame_start, sclk, sdata, load;
  int n_fail = 0, checks = 0, tp, np, te, ta, tc, ns, nr, sb, se, base;
  logic [31:0] rst [5] = '{32'h0000_0010, 32'h0000_0008, 32'h0000_0000, 32'h0000_0004, 32'h0000_0000};
  logic [3:0] code [4] = '{4'h0, 4'h2, 4'h3, 4'hf};
  always #4 i_clk = ~i_clk;
  isr_ctrl_model isr_ctrl_model_inst (.i_clk, .o_line_adv(line_adv), .o_frame_start(frame_start),
    .o_sclk(sclk), .o_sdata(sdata), .o_load(load));
  isr_top isr_top_inst (.i_clk, .i_reset, .i_line_adv(line_adv), .i_frame_start(frame_start),
    .i_par_sclk(sclk), .i_par_sdata(sdata), .i_par_load(load), .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_pix_valid, .o_eol, .o_eof, .o_sample_signal,
    .o_sample_reset, .o_analog_output_a_valid(a_v), .o_analog_output_b_valid(b_v), .o_adc_clk(),
    .o_adc_valid(adc_v));
  task tally_and_finish;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    i_psel <= 1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1;
    n = 0;
    do
      @(posedge i_clk);
    while (o_pready !== 1'b1 && ++n < 20);
    n_fail += (n == 20);
    if (n == 20) tally_and_finish;
    rdv = o_prdata;
    err = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
  endtask
  task run_line(input int h);
    int k;
    isr_ctrl_model_inst.line(h);
    {k, tp, np, te, ta, tc, ns, nr, sb, se} = '0;
    repeat (60)
    begin
      @(posedge i_clk);
      #1;
      k++;
      if (o_pix_valid === 1'b1 && tp == 0) tp = k;
      np += (o_pix_valid === 1'b1);
      if (o_eol === 1'b1 && te == 0) te = k;
      if (a_v === 1'b1 && ta == 0) ta = k;
      if (adc_v === 1'b1 && tc == 0) tc = k;
      ns += (o_sample_signal === 1'b1);
      nr += (o_sample_reset === 1'b1);
      sb |= (b_v === 1'b1);
      se |= (o_eof === 1'b1);
    end
    chk("pixels", np, 5);
    chk("eol", te, tp + np + 1);
    chk("signal sample", ns, 2);
    chk("reset sample", nr, 2);
  endtask
  initial
  begin
    repeat (8) @(posedge i_clk);
    i_reset <= 0;
    chk("idle pv", o_pix_valid, 0);
    foreach (rst[i])
    begin
      apb(0, 12'(i * 4), 0);
      chk("reset value", rdv, rst[i]);
    end
    apb(1, 12'h040, 32'h0000_0123);
    chk("slverr", err, 1);
    apb(0, 12'h040, 0);
    chk("unmapped", rdv, 0);
    apb(1, 12'h000, 32'h0000_0005);
    apb(1, 12'h004, 32'h0000_0002);
    apb(0, 12'h000, 0);
    chk("pixels reg", rdv, 5);
    isr_ctrl_model_inst.frame();
    run_line(1);
    base = tp;
    chk("eof early", se, 0);
    chk("output a", ta, tp + 4);
    chk("output b", sb, 1);
    chk("converter", tc, ta + 4);
    run_line(3);
    chk("suspend", tp, base);
    chk("eof", se, 1);
    isr_ctrl_model_inst.upload(16'h4001);
    apb(0, 12'h010, 0);
    chk("upload", rdv, 1);
    foreach (code[i])
    begin
      isr_ctrl_model_inst.upload({4'h2, 4'h0, code[i], code[i]});
      run_line(1);
      chk("delay", tp, base + (code[i] > 2 ? code[i] - 2 : 0));
      chk("one output b", sb, 0);
      if (code[i] == 0) chk("one output a", ta, tp + 5);
      if (code[i] == 0) chk("one converter", tc, ta + 4);
    end
    isr_ctrl_model_inst.line(1);
    tp = 0;
    while (o_eol !== 1'b1 && ++tp < 100)
    begin
      @(posedge i_clk);
      #1;
    end
    n_fail += (tp == 100);
    if (tp == 100) tally_and_finish;
    repeat (2) @(posedge i_clk);
    run_line(1);
    chk("free run delay", tp, base + (4'hf - 2));
    apb(0, 12'h020, 0);
    chk("status", rdv, 32'h0000_0008);
    @(posedge i_clk) i_reset <= 1;
    repeat (2) @(posedge i_clk);
    i_reset <= 0;
    apb(0, 12'h000, 0);
    chk("pixels after reset", rdv, rst[0]);
    apb(0, 12'h020, 0);
    chk("status after reset", rdv, 0);
    tally_and_finish;
  end
endmodule
